// file: rtl/dpe_pkg.sv
// Constants for the drive process-data error signalling block
// Notes on behaviour
// - Refused mode request sets mode status bit 6
// - Refused request leaves running motion untouched
// - Refusal cause stored as readable error number
// - Mode error code is 16-bit read-only value
// - Refused dimension setting in speed: C4, 0006
// - Refusal also sends diagnostic telegram with number
// - Async fault brakes motor or disables power stage
// - Async fault enters state 7 or 9
// - Status bit 5 internal, bit 6 external fault
// - Internal fault sets its own source bit
// - External fault sets its own source bit
// - The async fault that sets the error flag gets a readable stop number; a later fault keeps it
// - Limit switch: ramp to standstill, set error flag
// - Status bit 14 motion-done in a fault only after real standstill; mode status bit 5 follows motion_done
// - Positive limit: 8047 braking, C047 stopped
`default_nettype none
package dpe_pkg;
  // Mode request byte layout
  localparam int REQ_TOGGLE_BIT = 7;
  localparam int MODE_W         = 5;
  // Mode status byte layout
  localparam int MST_ACK_BIT    = 7;
  localparam int MST_REJECT_BIT = 6;
  localparam int MST_DONE_BIT   = 5;
  // Drive status word layout
  localparam int DST_INT_BIT    = 5;
  localparam int DST_EXT_BIT    = 6;
  localparam int DST_INFO_BIT   = 13;
  localparam int DST_END_BIT    = 14;
  localparam int DST_ERR_BIT    = 15;
  // Drive command byte layout
  localparam int CMD_ENABLE_BIT = 1;
  localparam int CMD_FRESET_BIT = 3;
  // Operating state codes
  localparam logic [3:0] OPST_READY     = 4'h4;
  localparam logic [3:0] OPST_ENABLED   = 4'h6;
  localparam logic [3:0] OPST_QUICKSTOP = 4'h7;
  localparam logic [3:0] OPST_FAULT     = 4'h9;
  // Operating mode codes
  localparam logic [4:0] MODE_NONE      = 5'h00;
  localparam logic [4:0] MODE_DIMSET    = 5'h02;
  localparam logic [4:0] MODE_PTP       = 5'h03;
  localparam logic [4:0] MODE_SPEED     = 5'h04;
  localparam logic [4:0] MODE_REFMOVE   = 5'h12;
  // Refusal causes and stop numbers, plain values
  localparam logic [15:0] ERR_NONE         = 16'h0000;
  localparam logic [15:0] ERR_UNKNOWN_MODE = 16'h0101;
  localparam logic [15:0] ERR_MODE_BUSY    = 16'h0102;
  localparam logic [15:0] ERR_IN_FAULT     = 16'h0103;
  localparam logic [15:0] STOP_INTERNAL    = 16'h0201;
  localparam logic [15:0] STOP_LIMIT_POS   = 16'h0202;
  localparam logic [15:0] STOP_LIMIT_NEG   = 16'h0203;
  localparam logic [15:0] STOP_EXT_STOP    = 16'h0204;
  // External monitor bit positions
  localparam int EXT_POSITIVE_LIMIT_INPUT_BIT   = 0;
  localparam int EXT_LIMN_BIT   = 1;
  localparam int EXT_STOP_BIT   = 2;
  localparam int EXT_W          = 3;
  // Reset values
  localparam logic [7:0]  MST_RESET = 8'h00;
  localparam logic [15:0] DST_RESET = 16'h0004;
endpackage : dpe_pkg
`default_nettype wire

// file: rtl/dpe_sync.sv
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module dpe_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  // Both stages in one state word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpe_sync_st_t;

  dpe_sync_st_t st_q;     // Registered state
  dpe_sync_st_t st_d;     // Next state

  // First stage only feeds the second stage
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
  end

  // Plain register, constants on reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;
endmodule : dpe_sync
`default_nettype wire

// file: rtl/dpe_sticky.sv
// Sticky fault-source bits, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module dpe_sticky #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set_bits,
  input  wire logic         clear_all,
  output logic      [W-1:0] bits_out
);
  // Only one field, kept as struct for uniform style
  typedef struct packed {
    logic [W-1:0] bits;
  } dpe_sticky_st_t;

  dpe_sticky_st_t st_q;   // Registered bits
  dpe_sticky_st_t st_d;   // Next bits

  // Clear first, then a live source sets again
  always_comb begin
    st_d = st_q;
    if (clear_all) begin
      st_d.bits = '0;
    end
    st_d.bits = st_d.bits | set_bits;
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bits_out = st_q.bits;
endmodule : dpe_sticky
`default_nettype wire

// file: rtl/dpe_top.sv
// Mode request checking and fault signalling of the drive process data
`timescale 1ns/1ps
`default_nettype none
module dpe_top #(
  parameter int INT_W = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             request_strobe,
  input  wire logic [7:0]       mode_request_byte,
  input  wire logic [7:0]       drive_command_byte,
  input  wire logic             motion_active,
  input  wire logic             motor_standstill,
  input  wire logic             motion_done,
  input  wire logic             setpoint_reached,
  input  wire logic [INT_W-1:0] internal_fault_in,
  input  wire logic             positive_limit_input,
  input  wire logic             negative_limit_input,
  input  wire logic             external_stop_input,
  output logic      [7:0]       mode_status_byte,
  output logic      [15:0]      drive_status_word,
  output logic      [15:0]      refused_mode_error_code,
  output logic      [INT_W-1:0] internal_fault_bits,
  output logic      [dpe_pkg::EXT_W-1:0] external_monitor_bits,
  output logic      [15:0]      last_stop_error_number,
  output logic                  diag_valid,
  output logic      [15:0]      diag_error_number,
  output logic                  mode_start,
  output logic      [4:0]       active_mode,
  output logic                  brake_request,
  output logic                  power_enable
);
  import dpe_pkg::*;

  // Whole block state
  typedef struct packed {
    logic             ack_tog;    // Last toggle taken over
    logic             reject;     // Mode reject flag
    logic [4:0]       mode;       // Running mode
    logic [15:0]      err_code;   // Refusal cause
    logic [3:0]       op_state;   // Operating state
    logic             enable;     // Power stage wanted
    logic             x_err;      // Error flag
    logic             x_end;      // Motion done flag
    logic             int_flt;    // Internal fault source
    logic             ext_flt;    // External fault source
    logic [15:0]      stop_num;   // Last stop number
    logic             diag_v;     // Diagnostic telegram pulse
    logic [15:0]      diag_n;     // Diagnostic number
    logic             start;      // Accepted request pulse
    logic             brake;      // Ramp to standstill
    logic             pwr;        // Power stage on
    logic [7:0]       mst;        // Mode status byte
    logic [15:0]      dst;        // Drive status word
  } dpe_state_t;

  dpe_state_t st_q;               // Registered state
  dpe_state_t st_d;               // Next state

  logic [INT_W-1:0] int_sync;     // Synchronised internal sensors
  logic [EXT_W-1:0] ext_sync;     // Synchronised external pins
  logic [EXT_W-1:0] ext_pins;     // External pins grouped
  logic             fault_clear;  // Fault reset accepted
  logic             new_req;      // Toggled request seen
  logic [4:0]       req_mode;     // Requested mode code
  logic             mode_known;   // Mode code supported
  logic             req_busy;     // Mode needs standstill
  logic             int_now;      // Any internal sensor active
  logic             ext_now;      // Any external pin active

  assign ext_pins = {external_stop_input, negative_limit_input,
                     positive_limit_input};

  // Pins come from outside the clock domain
  dpe_sync #(.W(INT_W)) u_int_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .pin_in   (internal_fault_in),
    .sync_out (int_sync)
  );

  dpe_sync #(.W(EXT_W)) u_ext_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .pin_in   (ext_pins),
    .sync_out (ext_sync)
  );

  // Per-source fault bits, readable by the master
  dpe_sticky #(.W(INT_W)) u_int_bits (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .set_bits  (int_sync),
    .clear_all (fault_clear),
    .bits_out  (internal_fault_bits)
  );

  dpe_sticky #(.W(EXT_W)) u_ext_bits (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .set_bits  (ext_sync),
    .clear_all (fault_clear),
    .bits_out  (external_monitor_bits)
  );

  // Request decode, kept outside the state update
  always_comb begin
    int_now    = |int_sync;
    ext_now    = |ext_sync;
    req_mode   = mode_request_byte[MODE_W-1:0];
    new_req    = request_strobe &&
                 (mode_request_byte[REQ_TOGGLE_BIT] != st_q.ack_tog);
    mode_known = (req_mode == MODE_DIMSET) || (req_mode == MODE_PTP) ||
                 (req_mode == MODE_SPEED)  || (req_mode == MODE_REFMOVE);
    // Coordinate changes only make sense with the motor at rest
    req_busy   = motion_active &&
                 ((req_mode == MODE_DIMSET) || (req_mode == MODE_REFMOVE));
    // Reset only once the motor stands and no source is live
    fault_clear = request_strobe && drive_command_byte[CMD_FRESET_BIT] &&
                  st_q.x_err && motor_standstill && !int_now && !ext_now;
  end

  // Next state
  always_comb begin
    st_d        = st_q;
    st_d.diag_v = 1'b0;
    st_d.start  = 1'b0;
    if (request_strobe) begin
      st_d.enable = drive_command_byte[CMD_ENABLE_BIT];
    end
    // Mode requests
    if (new_req) begin
      st_d.ack_tog = mode_request_byte[REQ_TOGGLE_BIT];
      if (st_q.x_err || !mode_known || req_busy) begin
        // Refused: running mode and motion stay as they are
        st_d.reject = 1'b1;
        st_d.err_code = st_q.x_err ? ERR_IN_FAULT :
                        (!mode_known ? ERR_UNKNOWN_MODE : ERR_MODE_BUSY);
        st_d.diag_v = 1'b1;
        st_d.diag_n = st_d.err_code;
      end else begin
        // Accepted request releases the reject flag
        st_d.reject = 1'b0;
        st_d.mode   = req_mode;
        st_d.start  = 1'b1;
      end
    end
    // Fault entry, internal takes precedence
    if (!st_q.x_err && (int_now || ext_now)) begin
      st_d.x_err    = 1'b1;
      st_d.int_flt  = int_now;
      st_d.ext_flt  = ext_now;
      st_d.x_end    = 1'b0;
      st_d.op_state = int_now ? OPST_FAULT : OPST_QUICKSTOP;
      if (int_now) begin
        st_d.stop_num = STOP_INTERNAL;
      end else if (ext_sync[EXT_POSITIVE_LIMIT_INPUT_BIT]) begin
        st_d.stop_num = STOP_LIMIT_POS;
      end else if (ext_sync[EXT_LIMN_BIT]) begin
        st_d.stop_num = STOP_LIMIT_NEG;
      end else begin
        st_d.stop_num = STOP_EXT_STOP;
      end
      st_d.diag_v = 1'b1;
      st_d.diag_n = st_d.stop_num;
    end else if (st_q.x_err && int_now && !st_q.int_flt) begin
      // Internal fault during quick stop escalates to fault
      st_d.int_flt  = 1'b1;
      st_d.op_state = OPST_FAULT;
    end else if (fault_clear) begin
      st_d.x_err    = 1'b0;
      st_d.int_flt  = 1'b0;
      st_d.ext_flt  = 1'b0;
      st_d.op_state = st_d.enable ? OPST_ENABLED : OPST_READY;
    end else if (!st_q.x_err) begin
      st_d.op_state = st_d.enable ? OPST_ENABLED : OPST_READY;
    end
    // Done flag: during a fault only real standstill counts
    if (st_d.x_err) begin
      st_d.x_end = (st_q.x_err && motor_standstill);
    end else begin
      st_d.x_end = motion_done;
    end
    // Stage reaction: ramp on external, power off on internal
    st_d.brake = st_d.x_err && !st_d.int_flt && !motor_standstill;
    st_d.pwr   = st_d.enable && !st_d.int_flt;
    // Returned bytes built from next values
    st_d.mst = {st_d.ack_tog, st_d.reject, motion_done, st_d.mode};
    st_d.dst = 16'h0000;
    st_d.dst[3:0]          = st_d.op_state;
    st_d.dst[DST_INT_BIT]  = st_d.int_flt;
    st_d.dst[DST_EXT_BIT]  = st_d.ext_flt;
    st_d.dst[DST_INFO_BIT] = setpoint_reached && !st_d.x_err;
    st_d.dst[DST_END_BIT]  = st_d.x_end;
    st_d.dst[DST_ERR_BIT]  = st_d.x_err;
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.mode     <= MODE_NONE;
      st_q.err_code <= ERR_NONE;
      st_q.op_state <= OPST_READY;
      st_q.mst      <= MST_RESET;
      st_q.dst      <= DST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign mode_status_byte        = st_q.mst;
  assign drive_status_word       = st_q.dst;
  assign refused_mode_error_code = st_q.err_code;
  assign last_stop_error_number  = st_q.stop_num;
  assign diag_valid              = st_q.diag_v;
  assign diag_error_number       = st_q.diag_n;
  assign mode_start              = st_q.start;
  assign active_mode             = st_q.mode;
  assign brake_request           = st_q.brake;
  assign power_enable            = st_q.pwr;

  // Checks next to the logic
  reject_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    new_req && (st_q.x_err || !mode_known || req_busy)
    |=> mode_status_byte[MST_REJECT_BIT] && diag_valid)
    else $error("refused request not flagged");
  reject_keeps_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    new_req && !st_q.x_err && req_busy
    |=> $stable(active_mode) && !mode_start)
    else $error("refused request changed motion");
  err_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    new_req && !st_q.x_err && mode_known && req_busy
    |=> refused_mode_error_code == ERR_MODE_BUSY)
    else $error("refusal cause not stored");
  diag_num_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    diag_valid && mode_status_byte[MST_REJECT_BIT] && !drive_status_word[15]
    |-> diag_error_number == refused_mode_error_code)
    else $error("diagnostic number mismatch");
  state_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st_q.x_err && !int_now && ext_now
    |=> drive_status_word[3:0] == OPST_QUICKSTOP
        && drive_status_word[DST_EXT_BIT])
    else $error("external fault did not enter quick stop");
  int_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st_q.x_err && int_now
    |=> drive_status_word[3:0] == OPST_FAULT
        && drive_status_word[DST_INT_BIT] && !power_enable)
    else $error("internal fault did not stop power stage");
  done_late_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(drive_status_word[DST_ERR_BIT])
    |-> !drive_status_word[DST_END_BIT])
    else $error("done set at fault detection");
  positive_limit_input_word_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    drive_status_word[DST_ERR_BIT] && !st_q.int_flt && st_q.ext_flt
    && st_q.enable && !motor_standstill && !fault_clear
    |=> drive_status_word[15:14] != 2'b11)
    else $error("done shown while still braking");
  stop_num_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(drive_status_word[DST_ERR_BIT])
    |-> last_stop_error_number != ERR_NONE && diag_valid)
    else $error("fault without stop number");
  reject_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_status_byte[MST_REJECT_BIT] && !new_req
    |=> mode_status_byte[MST_REJECT_BIT])
    else $error("reject flag dropped early");
  // Sensor during a quick stop must still cut the power stage
  escalate_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    st_q.x_err && !st_q.int_flt && int_now
    |=> drive_status_word[3:0] == OPST_FAULT
        && drive_status_word[DST_INT_BIT] && !power_enable)
    else $error("internal fault did not escalate quick stop");
  // Accepted fault reset leaves no error or source bit behind
  fault_clear_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    fault_clear
    |=> !drive_status_word[DST_ERR_BIT] && !drive_status_word[DST_INT_BIT]
        && !drive_status_word[DST_EXT_BIT])
    else $error("fault reset left error bits");
  // Moving motor hit by an external fault ramps down
  brake_ramp_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    $rose(drive_status_word[DST_ERR_BIT]) && !drive_status_word[DST_INT_BIT]
    && !$past(motor_standstill)
    |-> brake_request)
    else $error("external fault did not brake");
  // Done during a fault only once standstill was seen
  done_standstill_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    drive_status_word[DST_ERR_BIT] && drive_status_word[DST_END_BIT]
    |-> $past(motor_standstill))
    else $error("done shown before standstill");

  refused_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    mode_status_byte == 8'hC4 && drive_status_word == 16'h0006);
  positive_limit_input_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    drive_status_word == 16'h8047 ##[1:50] drive_status_word == 16'hC047);
  int_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(drive_status_word[DST_INT_BIT]));
  clear_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    fault_clear);
  esc_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    drive_status_word[3:0] == OPST_FAULT && drive_status_word[DST_EXT_BIT]);
endmodule : dpe_top
`default_nettype wire

// file: verif/dpe_master_model.sv
// Fieldbus master model issuing process-data telegrams
`timescale 1ns/1ps
`default_nettype none
module dpe_master_model (
  input  wire logic       ref_clk,
  output logic            request_strobe,
  output logic [7:0]      mode_request_byte,
  output logic [7:0]      drive_command_byte
);
  logic toggle_q; // Toggle bit of the last telegram sent

  // Quiet bus at time zero
  initial begin
    toggle_q           = 1'b0;
    request_strobe     = 1'b0;
    mode_request_byte  = 8'h00;
    drive_command_byte = 8'h00;
  end

  // One telegram; flip asks for a new mode, else a cyclic repeat
  task automatic send(input logic [4:0] mode, input logic [7:0] cmd,
                      input logic flip);
    @(posedge ref_clk);
    if (flip) begin
      toggle_q = ~toggle_q;
    end
    request_strobe     <= 1'b1;
    mode_request_byte  <= {toggle_q, 2'b00, mode};
    drive_command_byte <= cmd;
    @(posedge ref_clk);
    request_strobe     <= 1'b0;
    // Unqualified bytes scrambled so stale data is never trusted
    mode_request_byte  <= ~mode_request_byte;
    drive_command_byte <= ~drive_command_byte;
  endtask
endmodule // dpe_master_model
`default_nettype wire

// file: verif/tb_dpe_top.sv
// Self-checking bench for mode refusal and fault signalling
`timescale 1ns/1ps
`default_nettype none
module tb_dpe_top;
  import dpe_pkg::*;
  logic              ref_clk;           // 40 MHz clock
  logic              rst_n;             // Async reset, active low
  logic              request_strobe;    // From master model
  logic [7:0]        mode_request_byte; // From master model
  logic [7:0]        drive_command_byte;// From master model
  logic              motion_active;     // Motor model levels
  logic              motor_standstill;
  logic              motion_done;
  logic              setpoint_reached;
  logic [7:0]        internal_fault_in; // Internal sensor pins
  logic [EXT_W-1:0]  ext_pins;          // Limit and stop pins
  logic [7:0]        mode_status_byte;
  logic [15:0]       drive_status_word;
  logic [15:0]       refused_mode_error_code;
  logic [7:0]        internal_fault_bits;
  logic [EXT_W-1:0]  external_monitor_bits;
  logic [15:0]       last_stop_error_number;
  logic              diag_valid;
  logic [15:0]       diag_error_number;
  logic              mode_start;
  logic [4:0]        active_mode;
  logic              brake_request;
  logic              power_enable;
  int                errors;            // Mismatch count
  int                samples_checked;   // Comparison count
  logic [4:0]        codes [4];         // Accepted mode codes

  dpe_master_model dpe_master_model_inst (
    .ref_clk(ref_clk), .request_strobe(request_strobe),
    .mode_request_byte(mode_request_byte),
    .drive_command_byte(drive_command_byte));

  dpe_top #(.INT_W(8)) dpe_top_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .request_strobe(request_strobe),
    .mode_request_byte(mode_request_byte),
    .drive_command_byte(drive_command_byte),
    .motion_active(motion_active), .motor_standstill(motor_standstill),
    .motion_done(motion_done), .setpoint_reached(setpoint_reached),
    .internal_fault_in(internal_fault_in),
    .positive_limit_input(ext_pins[EXT_POSITIVE_LIMIT_INPUT_BIT]),
    .negative_limit_input(ext_pins[EXT_LIMN_BIT]),
    .external_stop_input(ext_pins[EXT_STOP_BIT]),
    .mode_status_byte(mode_status_byte),
    .drive_status_word(drive_status_word),
    .refused_mode_error_code(refused_mode_error_code),
    .internal_fault_bits(internal_fault_bits),
    .external_monitor_bits(external_monitor_bits),
    .last_stop_error_number(last_stop_error_number),
    .diag_valid(diag_valid), .diag_error_number(diag_error_number),
    .mode_start(mode_start), .active_mode(active_mode),
    .brake_request(brake_request), .power_enable(power_enable));

  // Free-running clock, 25 ns period
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Verdict and end of run
  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One comparison, four-state exact
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask

  // Telegram, then let the answering edge settle
  task automatic tx(input logic [4:0] m, input logic [7:0] c,
                    input logic f);
    dpe_master_model_inst.send(m, c, f);
    #1;
  endtask

  // Bounded wait for the error flag; a timeout counts an error and returns
  task automatic wait_err();
    int n;
    n = 0;
    while (drive_status_word[DST_ERR_BIT] !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 10) begin
        errors++;
        $display("BAD error_flag exp 1 got %b",
                 drive_status_word[DST_ERR_BIT]);
        return;
      end
    end
  endtask

  // Expected mode status from the master's toggle
  function automatic logic [15:0] mst(input logic rej, input logic [4:0] m);
    return {8'h00, dpe_master_model_inst.toggle_q, rej, 1'b0, m};
  endfunction

  // Main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    codes = '{MODE_DIMSET, MODE_PTP, MODE_SPEED, MODE_REFMOVE};
    rst_n = 1'b0;
    motion_active = 1'b0;
    motor_standstill = 1'b0;
    motion_done = 1'b0;
    setpoint_reached = 1'b0;
    internal_fault_in = 8'h00;
    ext_pins = '0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk("mode_status", {8'h00, MST_RESET}, {8'h00, mode_status_byte});
    chk("drive_status", DST_RESET, drive_status_word);
    chk("error_code", ERR_NONE, refused_mode_error_code);
    // Every mode code accepted while the motor is idle
    foreach (codes[i]) begin
      tx(codes[i], 8'h02, 1'b1);
      chk("mode_start", 16'h0001, {15'h0, mode_start});
      chk("active_mode", {11'h0, codes[i]}, {11'h0, active_mode});
      chk("mode_status", mst(1'b0, codes[i]), {8'h00, mode_status_byte});
    end
    // Unknown code, then a repeated toggle that must be ignored
    tx(5'h05, 8'h02, 1'b1);
    chk("mode_status", mst(1'b1, MODE_REFMOVE), {8'h00, mode_status_byte});
    chk("error_code", ERR_UNKNOWN_MODE, refused_mode_error_code);
    tx(MODE_SPEED, 8'h02, 1'b0);
    chk("mode_start", 16'h0000, {15'h0, mode_start});
    chk("mode_status", mst(1'b1, MODE_REFMOVE), {8'h00, mode_status_byte});
    // Speed running, then refused dimension setting and reference move
    @(posedge ref_clk);
    motion_active <= 1'b1;
    tx(MODE_SPEED, 8'h02, 1'b1);
    chk("mode_status", 16'h0004, {8'h00, mode_status_byte});
    chk("power_enable", 16'h0001, {15'h0, power_enable});
    tx(MODE_DIMSET, 8'h02, 1'b1);
    chk("mode_status", 16'h00C4, {8'h00, mode_status_byte});
    chk("drive_status", 16'h0006, drive_status_word);
    chk("error_code", ERR_MODE_BUSY, refused_mode_error_code);
    chk("diag", {15'h0, 1'b1}, {15'h0, diag_valid});
    chk("diag_number", ERR_MODE_BUSY, diag_error_number);
    chk("active_mode", {11'h0, MODE_SPEED}, {11'h0, active_mode});
    chk("mode_start", 16'h0000, {15'h0, mode_start});
    tx(MODE_REFMOVE, 8'h02, 1'b1);
    chk("mode_status", mst(1'b1, MODE_SPEED), {8'h00, mode_status_byte});
    // Each external source during a positioning move
    for (int i = 0; i < EXT_W; i++) begin
      @(posedge ref_clk);
      motion_active <= 1'b1;
      motor_standstill <= 1'b0;
      tx(MODE_PTP, 8'h02, 1'b1);
      chk("mode_status", mst(1'b0, MODE_PTP), {8'h00, mode_status_byte});
      @(posedge ref_clk);
      ext_pins <= EXT_W'(1) << i;
      wait_err();
      chk("drive_status", 16'h8047, drive_status_word);
      chk("stop_number", STOP_LIMIT_POS + 16'(i), last_stop_error_number);
      chk("diag_number", STOP_LIMIT_POS + 16'(i), diag_error_number);
      chk("diag", 16'h0001, {15'h0, diag_valid});
      chk("ext_bits", 16'(1 << i), 16'(external_monitor_bits));
      chk("brake", 16'h0001, {15'h0, brake_request});
      if (i == 0) begin
        tx(MODE_SPEED, 8'h02, 1'b1);
        chk("error_code", ERR_IN_FAULT, refused_mode_error_code);
        chk("drive_status", 16'h8047, drive_status_word);
      end
      @(posedge ref_clk);
      motion_active <= 1'b0;
      motor_standstill <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk("drive_status", 16'hC047, drive_status_word);
      chk("brake", 16'h0000, {15'h0, brake_request});
      @(posedge ref_clk);
      ext_pins <= '0;
      repeat (4) @(posedge ref_clk);
      tx(MODE_NONE, 8'h0A, 1'b0);
      chk("reset", 16'h0006, drive_status_word & 16'h806F);
    end
    // Internal fault, a refused reset while live, then recovery
    @(posedge ref_clk);
    internal_fault_in <= 8'h80;
    wait_err();
    chk("drive_status", 16'h8029, drive_status_word & 16'h806F);
    chk("int_bits", 16'h0080, {8'h00, internal_fault_bits});
    chk("stop_number", STOP_INTERNAL, last_stop_error_number);
    chk("diag_number", STOP_INTERNAL, diag_error_number);
    chk("power_enable", 16'h0000, {15'h0, power_enable});
    tx(MODE_NONE, 8'h0A, 1'b0);
    chk("drive_status", 16'h8029, drive_status_word & 16'h806F);
    @(posedge ref_clk);
    internal_fault_in <= 8'h00;
    repeat (4) @(posedge ref_clk);
    tx(MODE_NONE, 8'h0A, 1'b0);
    chk("reset", 16'h0006, drive_status_word & 16'h806F);
    // Stop input first, then a sensor escalates quick stop to fault
    @(posedge ref_clk);
    ext_pins <= 3'b100;
    wait_err();
    @(posedge ref_clk);
    internal_fault_in <= 8'h01;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("escalate", 16'h8069, drive_status_word & 16'h806F);
    chk("power_enable", 16'h0000, {15'h0, power_enable});
    chk("stop_number", STOP_EXT_STOP, last_stop_error_number);
    @(posedge ref_clk);
    internal_fault_in <= 8'h00;
    ext_pins <= '0;
    repeat (4) @(posedge ref_clk);
    tx(MODE_NONE, 8'h0A, 1'b0);
    chk("reset", 16'h0006, drive_status_word & 16'h806F);
    // Done and setpoint seen outside a fault
    @(posedge ref_clk);
    motion_done <= 1'b1;
    setpoint_reached <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("drive_status", 16'h6006, drive_status_word);
    chk("mode_done", 16'h0020, {8'h00, mode_status_byte & 8'h20});
    end_of_test();
  end
endmodule // tb_dpe_top
`default_nettype wire
